/* File: verilog/dif_core.sv */
// Purpose: Input terminal function logic of a motor inverter with APB access
// Assumes: term_in is asynchronous; motor_stopped, speed, PID and ADC words share core_clk
// Notes:   Contract
//
// Our own choices: the register addresses and the APB slave port.
module dif_core
  import dif_pkg::*;
#(
  parameter int unsigned TIMER_TICK_CYC = TIMER_UNIT_CYC,
  parameter int unsigned MS_TICK_CYC    = MS_CYC,
  parameter int unsigned BLINK_HALF_CYC = BLINK_CYC
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NTERM-1:0]    term_in,
  input  wire logic                motor_stopped,
  input  wire logic signed [15:0]  speed_cmd_in,
  input  wire logic signed [15:0]  pid_in,
  input  wire logic signed [11:0]  flux_ain,
  output logic                     second_set_active,
  output logic      [15:0]         accel_time,
  output logic      [15:0]         decel_time,
  output logic                     ramp_bypass,
  output logic                     run_fwd,
  output logic                     run_rev,
  output logic                     gate_enable,
  output logic                     trip_msg,
  output logic                     stop_led,
  output logic signed [15:0]       speed_cmd_out,
  output logic                     pid_active,
  output logic signed [15:0]       pid_out,
  output logic                     timer_out,
  output logic      [15:0]         spd_p_gain,
  output logic      [15:0]         spd_i_time,
  output logic      [15:0]         spd_filt_time,
  output logic                     spd_integral_en,
  output logic                     flux_from_analog,
  output logic signed [15:0]       flux_ref
);

  typedef struct packed {
    logic [NTERM-1:0]       s1;
    logic [NTERM-1:0]       s2;
    logic [NTERM-1:0]       prev;
    logic [NCFG-1:0][15:0]  cfg;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic                   set2;
    logic [15:0]            acc_t;
    logic [15:0]            dec_t;
    logic                   bypass;
    logic                   run_f;
    logic                   run_r;
    logic                   trip;
    logic                   gate;
    logic                   trip_msg;
    logic [31:0]            blink_pre;
    logic                   blink;
    logic                   stop_led;
    logic signed [15:0]     spd;
    logic                   pid_en;
    logic signed [15:0]     pid;
    logic [31:0]            tmr_pre;
    logic [15:0]            tmr_cnt;
    logic                   tmr_out;
    logic                   gsel_d;
    logic [11:0]            p_eff;
    logic [11:0]            p_delta;
    logic [31:0]            p_acc;
    logic [15:0]            i_t;
    logic [15:0]            f_t;
    logic                   integ;
    logic                   flux_sel;
    logic signed [15:0]     flux;
  } dif_state_t;

  dif_state_t            q;
  dif_state_t            next_q;
  logic [9:0]            idx;
  logic                  wr;
  logic                  trip_clr;
  logic [15:0]           wdat;
  logic [1:0]            xsel;
  logic                  run;
  dif_loop_mode_t        mode;
  logic [15:0]           dly;
  int unsigned           gbase;
  logic [11:0]           ptgt;
  logic [31:0]           ramp_cyc;
  logic [31:0]           acc_sum;
  logic signed [21:0]    fprod;
  logic [15:0]           status;

  always_comb begin
    next_q = q;
    // Two-stage sync; only s2 and prev feed logic
    next_q.s1   = term_in;
    next_q.s2   = q.s1;
    next_q.prev = q.s2;

    // APB slave: pready in first access cycle, writes at that edge
    idx      = paddr[11:2];
    xsel     = {q.s2[T_XHI], q.s2[T_XLO]};
    wr       = psel & penable & q.pready & pwrite & ~q.pslverr;
    trip_clr = wr && idx == 10'(REG_CTRL) && pwdata[CTRL_CLR];
    next_q.pready  = psel & ~penable;
    next_q.pslverr = psel & ~penable & (idx > 10'(REG_STATUS) || paddr[1:0] != 2'h0);
    status = {8'h00, xsel, q.pid_en, q.run_r, q.run_f, q.tmr_out, q.trip, q.set2};
    next_q.prdata = 32'h0000_0000;
    if (idx == 10'(REG_STATUS)) begin
      next_q.prdata = {16'h0000, status};
    end else if (idx < 10'(NCFG)) begin
      next_q.prdata = {16'h0000, q.cfg[idx[4:0]]};
    end
    // Writes clamp to the documented ranges
    wdat = pwdata[15:0];
    if (idx == 10'(REG_CTRL)) begin
      wdat = pwdata[15:0] & CFG_MAX[REG_CTRL];
    end else if (idx < 10'(NCFG) && wdat > CFG_MAX[idx[4:0]]) begin
      wdat = CFG_MAX[idx[4:0]];
    end
    if ((idx == 10'(REG_TON) || idx == 10'(REG_TOFF)) && wdat < TMR_MIN) begin
      wdat = TMR_MIN;
    end
    if (wr && idx < 10'(NCFG)) begin
      next_q.cfg[idx[4:0]] = wdat;
    end

    // Motor set follows the terminal only at standstill
    if (q.s2[T_SET2] != q.set2 && motor_stopped) begin
      next_q.set2 = q.s2[T_SET2];
    end

    // Ramp set select; zero time means the fastest the loop can follow
    next_q.bypass = q.s2[T_BYP];
    next_q.acc_t  = q.s2[T_BYP] ? 16'h0000 : q.cfg[REG_ACC1 + int'(xsel)];
    next_q.dec_t  = q.s2[T_BYP] ? 16'h0000 : q.cfg[REG_DEC1 + int'(xsel)];

    // Run command, latched on falling edge of a pulse in three-wire mode
    if (q.cfg[REG_CTRL][CTRL_3W]) begin
      if (!q.s2[T_3W]) begin
        next_q.run_f = 1'b0;
        next_q.run_r = 1'b0;
      end else if (q.prev[T_FWD] && !q.s2[T_FWD]) begin
        next_q.run_f = 1'b1;
        next_q.run_r = 1'b0;
      end else if (q.prev[T_REV] && !q.s2[T_REV]) begin
        next_q.run_f = 1'b0;
        next_q.run_r = 1'b1;
      end
    end else begin
      next_q.run_f = q.s2[T_FWD];
      next_q.run_r = q.s2[T_REV] & ~q.s2[T_FWD];
    end

    // Trip latch: open contact wins over a clear in the same cycle
    next_q.trip     = (q.trip & ~trip_clr) | ~q.s2[T_TRIPN];
    next_q.gate     = ~next_q.trip;
    next_q.trip_msg = next_q.trip;
    if (next_q.trip) begin
      next_q.run_f = 1'b0;  // Coasting motor must not restart by itself
      next_q.run_r = 1'b0;
    end
    if (q.blink_pre >= BLINK_HALF_CYC - 32'd1) begin
      next_q.blink_pre = 32'h0000_0000;
      next_q.blink     = ~q.blink;
    end else begin
      next_q.blink_pre = q.blink_pre + 32'h0000_0001;
    end
    next_q.stop_led = q.trip & q.blink;

    // Direction inhibits on the speed command
    if ((q.s2[T_FINH] && speed_cmd_in > 16'sh0000)
        || (q.s2[T_RINH] && speed_cmd_in < 16'sh0000)) begin
      next_q.spd = 16'sh0000;
    end else begin
      next_q.spd = speed_cmd_in;
    end

    // Process loop gating; illegal mode code blocks like disable
    run  = q.run_f | q.run_r;
    mode = dif_loop_mode_t'(q.cfg[REG_CTRL][CTRL_MODE +: 2]);
    unique case (mode)
      DIF_LOOP_DISABLE:  next_q.pid_en = 1'b0;
      DIF_LOOP_ENABLE:   next_q.pid_en = run;
      DIF_LOOP_TERMINAL: next_q.pid_en = run & ~q.s2[T_PDIS];
      default:           next_q.pid_en = 1'b0;
    endcase
    next_q.pid = next_q.pid_en ? pid_in : 16'sh0000;

    // Delay timer; prescaler restarts on each input change for exact delays
    dly = q.tmr_out ? q.cfg[REG_TOFF] : q.cfg[REG_TON];
    if (q.s2[T_TMR] == q.tmr_out) begin
      next_q.tmr_pre = 32'h0000_0000;
      next_q.tmr_cnt = 16'h0000;
    end else if (q.tmr_pre >= TIMER_TICK_CYC - 32'd1) begin
      next_q.tmr_pre = 32'h0000_0000;
      if (q.tmr_cnt + 16'h0001 >= dly) begin
        next_q.tmr_out = q.s2[T_TMR];
        next_q.tmr_cnt = 16'h0000;
      end else begin
        next_q.tmr_cnt = q.tmr_cnt + 16'h0001;
      end
    end else begin
      next_q.tmr_pre = q.tmr_pre + 32'h0000_0001;
    end

    // Speed loop gain set and loop type
    gbase          = q.s2[T_GSEL] ? REG_G2 : REG_G1;
    ptgt           = q.cfg[gbase + G_P][11:0];
    next_q.i_t     = q.cfg[gbase + G_I];
    next_q.f_t     = q.cfg[gbase + G_F];
    next_q.integ   = q.s2[T_PPI];
    next_q.gsel_d  = q.s2[T_GSEL];
    // Bresenham style P ramp: no divider, one step at most per cycle
    ramp_cyc = 32'(q.cfg[REG_GRAMP]) * 32'(MS_TICK_CYC);
    acc_sum  = q.p_acc + {20'h00000, q.p_delta};
    if (q.s2[T_GSEL] != q.gsel_d) begin
      next_q.p_delta = (ptgt > q.p_eff) ? ptgt - q.p_eff : q.p_eff - ptgt;
      next_q.p_acc   = 32'h0000_0000;
    end else if (q.p_eff != ptgt) begin
      if (q.p_delta == 12'h000 || ramp_cyc == 32'h0000_0000) begin
        next_q.p_eff = ptgt;
      end else if (acc_sum >= ramp_cyc) begin
        next_q.p_acc = acc_sum - ramp_cyc;
        next_q.p_eff = (ptgt > q.p_eff) ? q.p_eff + 12'h001 : q.p_eff - 12'h001;
      end else begin
        next_q.p_acc = acc_sum;
      end
    end

    // Flux reference from ADC, scaled to 0.1 % of rated flux
    fprod           = 22'(flux_ain) * FLUX_GAIN;
    next_q.flux_sel = q.s2[T_FLUX];
    next_q.flux     = q.s2[T_FLUX] ? 16'(fprod >>> FLUX_SHIFT) : FLUX_NOM;
  end

  // State register; reset loads constants only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q       <= '0;
      q.s1    <= TERM_RST;
      q.s2    <= TERM_RST;
      q.prev  <= TERM_RST;
      q.cfg   <= CFG_RST;
      q.p_eff <= CFG_RST[REG_G1][11:0];
    end else begin
      q <= next_q;
    end
  end

  assign prdata            = q.prdata;
  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign second_set_active = q.set2;
  assign accel_time        = q.acc_t;
  assign decel_time        = q.dec_t;
  assign ramp_bypass       = q.bypass;
  assign run_fwd           = q.run_f;
  assign run_rev           = q.run_r;
  assign gate_enable       = q.gate;
  assign trip_msg          = q.trip_msg;
  assign stop_led          = q.stop_led;
  assign speed_cmd_out     = q.spd;
  assign pid_active        = q.pid_en;
  assign pid_out           = q.pid;
  assign timer_out         = q.tmr_out;
  assign spd_p_gain        = {4'h0, q.p_eff};
  assign spd_i_time        = q.i_t;
  assign spd_filt_time     = q.f_t;
  assign spd_integral_en   = q.integ;
  assign flux_from_analog  = q.flux_sel;
  assign flux_ref          = q.flux;

  default clocking dif_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_set_change_stopped: assert property ($changed(q.set2) |-> $past(motor_stopped))
    else $error("motor set changed while running");
  a_ramp_select: assert property (!$past(q.s2[T_BYP]) && !$past(rst)
      |-> q.acc_t == $past(q.cfg[REG_ACC1 + int'({q.s2[T_XHI], q.s2[T_XLO]})]))
    else $error("accel time not from selected set");
  a_bypass_zero: assert property ($past(q.s2[T_BYP]) && !$past(rst)
      |-> q.acc_t == 16'h0000 && q.dec_t == 16'h0000)
    else $error("bypass did not force shortest ramp");
  a_three_wire_latch: assert property (q.cfg[REG_CTRL][CTRL_3W] && q.s2[T_3W] && q.s2[T_TRIPN]
      && q.trip == 1'b0 && q.prev[T_FWD] && !q.s2[T_FWD] |=> q.run_f)
    else $error("three-wire pulse not latched");
  a_three_wire_release: assert property (q.cfg[REG_CTRL][CTRL_3W] && !q.s2[T_3W]
      |=> !q.run_f && !q.run_r)
    else $error("run not released by stop input");
  a_trip_gate: assert property (!q.s2[T_TRIPN] |=> !q.gate && q.trip_msg
      ##1 (!q.gate || $past(trip_clr)))
    else $error("gating not removed on trip");
  a_trip_hold: assert property (q.trip && !trip_clr
      |=> q.trip ##1 (q.trip || $past(trip_clr)))
    else $error("trip latch dropped without clear");
  a_fwd_inhibit: assert property ($past(q.s2[T_FINH]) && $past(speed_cmd_in) > 16'sh0000
      && !$past(rst) |-> q.spd == 16'sh0000)
    else $error("positive speed passed forward inhibit");
  a_rev_inhibit: assert property ($past(q.s2[T_RINH]) && $past(speed_cmd_in) < 16'sh0000
      && !$past(rst) |-> q.spd == 16'sh0000)
    else $error("negative speed passed reverse inhibit");
  a_pid_run_gate: assert property (!(q.run_f || q.run_r) |=> !q.pid_en && q.pid == 16'sh0000)
    else $error("process loop active without run");
  a_timer_steady: assert property ($rose(q.tmr_out) |-> $past(q.s2[T_TMR], 2) && $past(q.s2[T_TMR]))
    else $error("timer output rose without steady input");
  a_gain_select: assert property (!$past(rst) |-> q.i_t
      == $past(q.s2[T_GSEL] ? q.cfg[REG_G2 + G_I] : q.cfg[REG_G1 + G_I]))
    else $error("integral time not from selected set");

endmodule // dif_core

/* File: verilog/dif_pkg.sv */
// Purpose: Shared constants for the drive input function block
// Assumes: 40 MHz core clock, APB word registers, terminal vector sampled raw
// Notes:   Times are kept in their own units; cycle counts derive from them
package dif_pkg;
  // Clock and time bases
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned TIMER_UNIT_NS  = 100_000_000;  // 0.1 s timer step
  localparam int unsigned TIMER_UNIT_CYC = TIMER_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_NS          = 1_000_000;
  localparam int unsigned MS_CYC         = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned BLINK_NS       = 500_000_000;  // Stop indicator half period
  localparam int unsigned BLINK_CYC      = BLINK_NS / CLK_PERIOD_NS;

  // Terminal vector bit positions
  localparam int NTERM   = 15;
  localparam int T_SET2  = 0;
  localparam int T_XLO   = 1;
  localparam int T_XHI   = 2;
  localparam int T_BYP   = 3;
  localparam int T_FWD   = 4;
  localparam int T_REV   = 5;
  localparam int T_3W    = 6;
  localparam int T_TRIPN = 7;
  localparam int T_FINH  = 8;
  localparam int T_RINH  = 9;
  localparam int T_PDIS  = 10;
  localparam int T_TMR   = 11;
  localparam int T_GSEL  = 12;
  localparam int T_PPI   = 13;
  localparam int T_FLUX  = 14;
  localparam logic [NTERM-1:0] TERM_RST = 15'h0080;  // Trip contact reads closed

  // Register word indices; byte address is four times the index
  localparam int REG_CTRL   = 0;
  localparam int REG_ACC1   = 1;
  localparam int REG_DEC1   = 5;
  localparam int REG_TON    = 9;
  localparam int REG_TOFF   = 10;
  localparam int REG_G1     = 11;
  localparam int REG_G2     = 14;
  localparam int REG_GRAMP  = 17;
  localparam int REG_STATUS = 18;
  localparam int NCFG       = 18;
  localparam int G_P        = 0;
  localparam int G_I        = 1;
  localparam int G_F        = 2;

  // Control register fields
  localparam int CTRL_3W   = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_CLR  = 3;

  typedef enum logic [1:0] {
    DIF_LOOP_DISABLE,
    DIF_LOOP_ENABLE,
    DIF_LOOP_TERMINAL
  } dif_loop_mode_t;

  // Reset values: ramp times in 0.01 s, timers in 0.1 s, P in 0.1 %, ms otherwise
  localparam logic [NCFG-1:0][15:0] CFG_RST = {
    16'h0064, 16'h0000, 16'h0064, 16'h01F4, 16'h0000, 16'h0064, 16'h01F4,
    16'h000A, 16'h000A, 16'h01F4, 16'h0190, 16'h012C, 16'h00C8,
    16'h01F4, 16'h0190, 16'h012C, 16'h00C8, 16'h0000};
  localparam logic [NCFG-1:0][15:0] CFG_MAX = {
    16'hFFFF, 16'h4E20, 16'hC350, 16'h07D0, 16'h4E20, 16'hC350, 16'h07D0,
    16'h8CA0, 16'h8CA0, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0007};
  localparam logic [15:0] TMR_MIN = 16'h0001;

  // Flux scaling: full scale ADC code maps to 100.0 % in 0.1 % steps
  localparam logic signed [21:0] FLUX_GAIN  = 22'sh0003E8;
  localparam int                 FLUX_SHIFT = 11;
  localparam logic [15:0]        FLUX_NOM   = 16'h03E8;
endpackage

/* File: bench/dif_term_model.sv */
// Purpose: Switch bank that stands in front of the input terminals
// Assumes: The bench asks for a terminal image just after a rising edge
// Notes:   Contacts move one edge after the request, like a relay output
module dif_term_model
  import dif_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic [NTERM-1:0] want,
  output logic      [NTERM-1:0] term_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Trip contact starts closed so the drive powers up healthy
  initial term_in = TERM_RST;
  // Contacts follow the request one edge later, never mid-cycle
  always @(posedge core_clk) term_in <= want;
endmodule // dif_term_model

/* File: bench/drive_input_function_logic_tb_top.sv */
// Purpose: Self-checking bench for the input terminal function block
// Assumes: Short tick parameters so timers and blink finish quickly
// Notes:   Terminals go through the switch model, registers through APB
module drive_input_function_logic_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dif_pkg::*;
  // Switch model edge plus three edges inside the block
  localparam int LAT = 4;
  logic               core_clk, rst, psel, penable, pwrite, pready, pslverr, motor_stopped;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [NTERM-1:0]   want, term_in;
  logic signed [15:0] speed_cmd_in, pid_in, speed_cmd_out, pid_out, flux_ref, spd;
  logic signed [11:0] flux_ain;
  logic               second_set_active, ramp_bypass, run_fwd, run_rev, gate_enable;
  logic               trip_msg, stop_led, pid_active, timer_out, spd_integral_en;
  logic               flux_from_analog, err, on;
  logic [15:0]        accel_time, decel_time, spd_p_gain, spd_i_time, spd_filt_time;
  int                 bad_count = 0;
  int                 checks_done = 0;
  int                 cyc = 0;
  int                 ones;

  dif_core #(.TIMER_TICK_CYC(10), .MS_TICK_CYC(4), .BLINK_HALF_CYC(8)) i_dut (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .term_in, .motor_stopped, .speed_cmd_in, .pid_in, .flux_ain,
    .second_set_active, .accel_time, .decel_time, .ramp_bypass, .run_fwd, .run_rev,
    .gate_enable, .trip_msg, .stop_led, .speed_cmd_out, .pid_active, .pid_out,
    .timer_out, .spd_p_gain, .spd_i_time, .spd_filt_time, .spd_integral_en,
    .flux_from_analog, .flux_ref);
  dif_term_model i_terms (.core_clk, .want, .term_in);

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One APB transfer; request holds until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready wait", n, 32'h1);
  endtask

  task automatic term(input int b, input logic v);
    @(posedge core_clk);
    want[b] <= v;
  endtask

  // Outputs are looked at mid-cycle, well clear of the launching edge
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Hang guard, far above the roughly 700 cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    want = TERM_RST;
    motor_stopped = 1'b0;
    speed_cmd_in = 16'sh0000;
    pid_in = 16'sh0141;
    flux_ain = 12'sh000;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    settle(LAT);
    chk("gate", gate_enable, 1);
    chk("accel", accel_time, 32'h00C8);
    chk("flux idle", flux_ref, 32'h03E8);
    chk("pid idle", pid_active, 0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'h004 + 12'(4 * i), 32'h0);
      chk("ramp reg", rd, 32'(200 + 100 * (i % 4)));
    end
    apb(1'b0, 12'h04C, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    // Every selector code, then bypass on top of code 3
    for (int c = 0; c < 4; c++) begin
      term(T_XLO, c[0]);
      term(T_XHI, c[1]);
      settle(LAT);
      chk("accel sel", accel_time, 32'(200 + 100 * c));
      chk("decel sel", decel_time, 32'(200 + 100 * c));
    end
    term(T_BYP, 1'b1);
    settle(LAT);
    chk("bypass", ramp_bypass, 32'h1);
    chk("bypass ramp", {accel_time, decel_time}, 32'h0);
    term(T_BYP, 1'b0);
    // Second motor set held off while running
    term(T_SET2, 1'b1);
    settle(LAT + 4);
    chk("set2 run", second_set_active, 0);
    @(posedge core_clk) motor_stopped <= 1'b1;
    settle(3);
    chk("set2 stop", second_set_active, 1);
    // Three-wire latch and release
    apb(1'b1, 12'h000, 32'h1);
    term(T_3W, 1'b1);
    term(T_FWD, 1'b1);
    term(T_FWD, 1'b0);
    settle(LAT);
    chk("3w latch", run_fwd, 1);
    term(T_3W, 1'b0);
    settle(LAT);
    chk("3w release", run_fwd, 0);
    term(T_3W, 1'b1);
    term(T_REV, 1'b1);
    term(T_REV, 1'b0);
    settle(LAT);
    chk("3w rev", {run_fwd, run_rev}, 32'h1);
    term(T_3W, 1'b0);
    settle(LAT);
    chk("3w rev release", run_rev, 0);
    // Inhibits: none, forward, reverse against both signs
    for (int k = 0; k < 6; k++) begin
      spd = (k % 2) ? -16'sd100 : 16'sd100;
      @(posedge core_clk) speed_cmd_in <= spd;
      term(T_FINH, k / 2 == 1);
      term(T_RINH, k / 2 == 2);
      settle(LAT);
      chk("speed", speed_cmd_out, (k == 2 || k == 5) ? 16'sh0000 : spd);
    end
    term(T_RINH, 1'b0);
    // Process loop truth table over all modes
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 4; r++) begin
        apb(1'b1, 12'h000, 32'(m << 1));
        term(T_FWD, r[0]);
        term(T_PDIS, r[1]);
        settle(LAT + 2);
        on = r[0] && (m == 1 || (m == 2 && !r[1]));
        chk("pid act", pid_active, on);
        chk("pid out", pid_out, on ? pid_in : 16'sh0000);
      end
    end
    term(T_FWD, 1'b0);
    term(T_PDIS, 1'b0);
    // Trip opens, blinks, stays latched after contact recloses
    term(T_TRIPN, 1'b0);
    settle(LAT);
    chk("trip", {gate_enable, trip_msg}, 32'h1);
    ones = 0;
    repeat (40) begin
      @(negedge core_clk);
      ones += int'(stop_led === 1'b1);
    end
    chk("blink", ones > 10 && ones < 30, 1);
    term(T_TRIPN, 1'b1);
    settle(LAT + 2);
    chk("trip held", trip_msg, 1);
    apb(1'b1, 12'h000, 32'h8);
    settle(2);
    chk("trip clear", gate_enable, 1);
    // Timer: floor of the delay, short pulse, then on and off delays
    apb(1'b1, 12'h024, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    chk("on dly min", rd, 32'h1);
    apb(1'b1, 12'h024, 32'h2);
    apb(1'b1, 12'h028, 32'h3);
    term(T_TMR, 1'b1);
    settle(4);
    term(T_TMR, 1'b0);
    settle(40);
    chk("tmr pulse", timer_out, 0);
    term(T_TMR, 1'b1);
    settle(15);
    chk("tmr early", timer_out, 0);
    settle(15);
    chk("tmr on", timer_out, 1);
    term(T_TMR, 1'b0);
    settle(25);
    chk("tmr hold", timer_out, 1);
    settle(15);
    chk("tmr off", timer_out, 0);
    // Gain set 2 clamps, selection and ramp
    for (int g = 0; g < 3; g++) begin
      apb(1'b1, 12'h038 + 12'(4 * g), 32'hFFFF);
      apb(1'b0, 12'h038 + 12'(4 * g), 32'h0);
      chk("clamp", rd, g == 0 ? 32'h07D0 : g == 1 ? 32'hC350 : 32'h4E20);
    end
    apb(1'b1, 12'h038, 32'h0208);
    apb(1'b1, 12'h03C, 32'h00C8);
    apb(1'b1, 12'h040, 32'h0007);
    apb(1'b1, 12'h044, 32'h0005);
    term(T_GSEL, 1'b1);
    settle(LAT);
    chk("set2 i f", {spd_i_time, spd_filt_time}, 32'h00C8_0007);
    chk("p ramping", spd_p_gain < 16'h0208, 1);
    settle(80);
    chk("p ramped", spd_p_gain, 32'h0208);
    term(T_PPI, 1'b1);
    settle(LAT);
    chk("pi", spd_integral_en, 1);
    term(T_PPI, 1'b0);
    settle(LAT);
    chk("p only", spd_integral_en, 0);
    // Flux from the analog word at both signs
    @(posedge core_clk) flux_ain <= 12'sh400;
    term(T_FLUX, 1'b1);
    settle(LAT);
    chk("flux pos", {flux_from_analog, flux_ref}, 32'h1_01F4);
    @(posedge core_clk) flux_ain <= 12'sh800;
    settle(3);
    chk("flux neg", flux_ref, -16'sd1000);
    wrap_up();
  end
endmodule // drive_input_function_logic_tb_top
